// file: verification/qcmsc_core_props.sv
`timescale 1ns/1ps
module qcmsc_props #(
  parameter int NCH = 4
) (
  // system
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic chip_select_n,
  input wire logic serial_port_data_oe_n,
  // channel state
  input wire logic [NCH*7-1:0] tx_slot_number,
  input wire logic [NCH-1:0] tx_highway_sel,
  input wire logic [NCH-1:0] tx_drive_a,
  input wire logic [NCH-1:0] tx_drive_b,
  input wire logic [NCH-1:0] channel_active_flag,
  input wire logic [NCH-1:0] pcm_valid,
  // configuration
  input wire logic irq_driver_type,
  input wire logic [3:0] master_freq_select,
  input wire logic master_freq_reserved,
  input wire logic internal_reset_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence pin_drop;
    $fell(reset_pin_n);
  endsequence
  sequence act_rise;
    $rose(channel_active_flag[0]);
  endsequence

  valid_needs_act_a: assert property ((pcm_valid & ~channel_active_flag) == '0)
    else $error("pcm valid on idle channel");
  valid_delay_a: assert property (act_rise |-> (!pcm_valid[0]) [*8])
    else $error("pcm valid too early");
  drive_gate_a: assert property (((tx_drive_a | tx_drive_b) & ~pcm_valid) == '0)
    else $error("highway driven without valid pcm");
  drive_b_sel_a: assert property ((pcm_valid & tx_highway_sel & ~tx_drive_b) == '0)
    else $error("highway b not driven");
  drive_a_sel_a: assert property ((pcm_valid & ~tx_highway_sel & ~tx_drive_a) == '0)
    else $error("highway a not driven");
  oe_release_a: assert property ($rose(chip_select_n) |-> ##4 serial_port_data_oe_n)
    else $error("data pin still driven");
  resv_code_a: assert property (master_freq_reserved ==
    (master_freq_select[1:0] == 2'b11 || master_freq_select[3:2] == 2'b11))
    else $error("reserved flag wrong");
  pin_reset_a: assert property (pin_drop |-> ##[1:6] !internal_reset_n)
    else $error("pin reset missing");
  reset_cfg_a: assert property ($rose(internal_reset_n) |-> irq_driver_type &&
    master_freq_select == 4'hA)
    else $error("config not defaulted");
  reset_slot_a: assert property ($rose(internal_reset_n) |->
    tx_slot_number == {7'd3, 7'd2, 7'd1, 7'd0} && channel_active_flag == '0)
    else $error("slots not defaulted");
endmodule : qcmsc_props

bind qcmsc_core qcmsc_props #(.NCH(NCH)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .chip_select_n(chip_select_n),
  .serial_port_data_oe_n(serial_port_data_oe_n), .tx_slot_number(tx_slot_number),
  .tx_highway_sel(tx_highway_sel), .tx_drive_a(tx_drive_a), .tx_drive_b(tx_drive_b),
  .channel_active_flag(channel_active_flag), .pcm_valid(pcm_valid),
  .irq_driver_type(irq_driver_type), .master_freq_select(master_freq_select),
  .master_freq_reserved(master_freq_reserved), .internal_reset_n(internal_reset_n)
);

// file: verification/qcmsc_host.sv
`timescale 1ns/1ps
module qcmsc_host (
  // clock
  input wire logic sys_clk,
  // serial port
  output logic spc,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial
  begin
    spc = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold

  // one select frame of n clocks carrying the low n bits of v
  task automatic xfer(input logic [15:0] v, input int n, output logic [7:0] r);
    cs_n <= 1'b0;
    hold(4);
    for (int i = n - 1; i >= 0; i--)
    begin
      r = {r[6:0], sdo};
      spc <= 1'b0;
      sdi <= v[i];
      hold(4);
      spc <= 1'b1;
      hold(4);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
    hold(6);
  endtask : xfer
endmodule : qcmsc_host

// file: verification/quad_codec_mpi_slot_config_tb.sv
`timescale 1ns/1ps
module quad_codec_mpi_slot_config_tb;
  import qcmsc_pkg::*;
  localparam logic [27:0] SLOT_DEF = {7'd3, 7'd2, 7'd1, 7'd0};
  localparam int REF_PERIOD = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic frame_sync = 1'b0;
  logic [3:0] chan_enable = 4'hF;
  logic spc, cs_n, sdi, sdo, sdo_oe_n, edge_sel, irq_t, chop, sig, msrc, resv;
  logic [27:0] tx_slot, rx_slot;
  logic [3:0] tx_hwy, rx_hwy, drv_a, drv_b, act, valid, freq;
  logic [2:0] rx_ofs, tx_ofs;
  logic [7:0] rx;
  logic chop_clk, int_rst_n, serial_port_data;
  logic [2:0] ref_cnt = 3'd0;
  int num_errors = 0;
  int n_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  // reference clock of eight system clocks
  always @(posedge sys_clk)
    ref_cnt <= ref_cnt + 3'd1;

  // undriven data line shows the inverse of the last bit
  assign serial_port_data = sdo_oe_n ? ~sdo : sdo;

  qcmsc_host u_host (.sys_clk(sys_clk), .spc(spc), .cs_n(cs_n), .sdi(sdi), .sdo(serial_port_data));

  qcmsc_core DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .serial_port_clock(spc), .chip_select_n(cs_n), .serial_port_data_in(sdi),
    .serial_port_data_out(sdo), .serial_port_data_oe_n(sdo_oe_n), .frame_sync(frame_sync),
    .ref_clk_2048(ref_cnt[2]), .chan_enable(chan_enable), .tx_slot_number(tx_slot),
    .tx_highway_sel(tx_hwy), .rx_slot_number(rx_slot), .rx_highway_sel(rx_hwy),
    .tx_drive_a(drv_a), .tx_drive_b(drv_b), .channel_active_flag(act), .pcm_valid(valid),
    .tx_edge_select(edge_sel), .rx_clock_offset(rx_ofs), .tx_clock_offset(tx_ofs),
    .irq_driver_type(irq_t), .chopper_divide_sel(chop), .highway_signaling_en(sig),
    .master_clock_source(msrc), .master_freq_select(freq), .master_freq_reserved(resv),
    .chopper_clk(chop_clk), .internal_reset_n(int_rst_n)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    u_host.xfer({8'h00, c}, 8, rx);
    u_host.xfer({8'h00, d}, 8, rx);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    u_host.xfer({8'h00, c}, 8, rx);
    u_host.xfer(16'h0000, 8, rx);
    check(rx, exp);
  endtask : rd

  // cycles between two rising chopper clock edges
  task automatic chop_period(input int exp);
    int n;
    int rises;
    logic prev;
    n = 0;
    rises = 0;
    prev = chop_clk;
    for (int k = 0; k < 300 && rises < 2; k++)
    begin
      u_host.hold(1);
      if (rises == 1)
        n++;
      if (chop_clk && !prev)
        rises++;
      prev = chop_clk;
    end
    if (rises < 2)
    begin
      num_errors++;
      $display("unexpected at %0t: chopper clock stalled", $time);
      report_and_stop();
    end
    else
      check(n, exp);
  endtask : chop_period

  task automatic fs_pulse();
    frame_sync <= 1'b1;
    u_host.hold(3);
    frame_sync <= 1'b0;
    u_host.hold(20);
  endtask : fs_pulse

  task automatic defaults_ok();
    check(tx_slot, SLOT_DEF);
    check(rx_slot, SLOT_DEF);
    check({tx_hwy, rx_hwy}, 8'h00);
    check({edge_sel, rx_ofs, tx_ofs}, 7'h00);
    check({irq_t, chop, sig, msrc, freq}, CONFIG_RST);
  endtask : defaults_ok

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    u_host.hold(4);
    rst_n <= 1'b1;
    u_host.hold(4);
    defaults_ok();
    chop_period(8 * REF_PERIOD);
    rd(CMD_RD_CONFIG, CONFIG_RST);
    $display("reset test done");
    chan_enable <= 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      wr(CMD_WR_CONFIG, {i[3:0], i[3:0]});
      check({irq_t, chop, sig, msrc, freq}, {i[3:0], i[3:0]});
      check(resv, i[1:0] == 2'b11 || i[3:2] == 2'b11);
    end
    chop_period(7 * REF_PERIOD);
    $display("config test done");
    wr(CMD_WR_CLK_SLOT, 8'hE9);
    check({edge_sel, rx_ofs, tx_ofs}, 7'h00);
    chan_enable <= 4'b0101;
    wr(CMD_WR_CLK_SLOT, 8'hE9);
    check({edge_sel, rx_ofs, tx_ofs}, {1'b1, 3'd5, 3'd1});
    rd(CMD_RD_CLK_SLOT, 8'hE9);
    wr(CMD_WR_TX_SLOT, 8'hFF);
    check(tx_slot, {7'd3, 7'd127, 7'd1, 7'd127});
    check(tx_hwy, 4'b0101);
    rd(CMD_RD_TX_SLOT, 8'hFF);
    chan_enable <= 4'b0010;
    wr(CMD_WR_RX_SLOT, 8'h85);
    check(rx_slot, {7'd3, 7'd2, 7'd5, 7'd0});
    check(rx_hwy, 4'b0010);
    rd(CMD_RD_RX_SLOT, 8'h85);
    u_host.xfer({8'h00, CMD_NOP}, 8, rx);
    check({tx_slot, tx_hwy}, {7'd3, 7'd127, 7'd1, 7'd127, 4'b0101});
    $display("slot test done");
    chan_enable <= 4'b1001;
    u_host.xfer({8'h00, CMD_ACTIVATE}, 8, rx);
    check(act, 4'b1001);
    fs_pulse();
    check(valid, 4'h0);
    fs_pulse();
    check(valid, 4'b1001);
    check({drv_a, drv_b}, 8'h99);
    wr(CMD_WR_CLK_SLOT, 8'h00);
    check({drv_a, drv_b}, 8'h81);
    $display("activate test done");
    u_host.xfer(16'h0047, 12, rx);
    u_host.xfer(16'h0000, 8, rx);
    check(rx, 8'hFF);
    u_host.xfer(16'h0004, 5, rx);
    check(act, 4'b1001);
    u_host.xfer(16'h0000, 16, rx);
    check(act, 4'h0);
    defaults_ok();
    $display("framing test done");
    chan_enable <= 4'h0;
    wr(CMD_WR_CONFIG, 8'h00);
    u_host.xfer({8'h00, CMD_HW_RESET}, 8, rx);
    defaults_ok();
    wr(CMD_WR_CONFIG, 8'h00);
    reset_pin_n <= 1'b0;
    u_host.hold(4);
    check(int_rst_n, 1'b0);
    reset_pin_n <= 1'b1;
    u_host.hold(6);
    check(int_rst_n, 1'b1);
    defaults_ok();
    $display("reset command test done");
    report_and_stop();
  end
endmodule : quad_codec_mpi_slot_config_tb

// file: verilog/qcmsc_core.sv
`timescale 1ns/1ps
module qcmsc_core #(
  parameter int NCH = 4
) (
  // system
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  // serial port from host
  input wire logic serial_port_clock,
  input wire logic chip_select_n,
  input wire logic serial_port_data_in,
  output logic serial_port_data_out,
  output logic serial_port_data_oe_n,
  // pcm timing
  input wire logic frame_sync,
  input wire logic ref_clk_2048,
  // channel enables from enable register block
  input wire logic [NCH-1:0] chan_enable,
  // per-channel settings
  output logic [NCH*7-1:0] tx_slot_number,
  output logic [NCH-1:0] tx_highway_sel,
  output logic [NCH*7-1:0] rx_slot_number,
  output logic [NCH-1:0] rx_highway_sel,
  output logic [NCH-1:0] tx_drive_a,
  output logic [NCH-1:0] tx_drive_b,
  output logic [NCH-1:0] channel_active_flag,
  output logic [NCH-1:0] pcm_valid,
  // shared timing settings
  output logic tx_edge_select,
  output logic [2:0] rx_clock_offset,
  output logic [2:0] tx_clock_offset,
  // global configuration
  output logic irq_driver_type,
  output logic chopper_divide_sel,
  output logic highway_signaling_en,
  output logic master_clock_source,
  output logic [3:0] master_freq_select,
  output logic master_freq_reserved,
  output logic chopper_clk,
  output logic internal_reset_n
);
  import qcmsc_pkg::*;

  // two-stage synchronisers for all pins except rst_n
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 6'h38;
      s2_r <= 6'h38;
    end
    else
    begin
      s1_r <= {reset_pin_n, serial_port_clock, chip_select_n, serial_port_data_in,
               frame_sync, ref_clk_2048};
      s2_r <= s1_r;
    end
  end
  logic pin_rst_n_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic fs_s;
  logic ref_s;
  assign {pin_rst_n_s, sclk_s, cs_n_s, sdi_s, fs_s, ref_s} = s2_r;

  // edge detection after synchronisation
  logic sclk_d_r;
  logic cs_n_d_r;
  logic fs_d_r;
  logic ref_d_r;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_d_r <= 1'b1;
      cs_n_d_r <= 1'b1;
      fs_d_r <= 1'b0;
      ref_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
      fs_d_r <= fs_s;
      ref_d_r <= ref_s;
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_start;
  logic cs_end;
  logic fs_rise;
  logic ref_rise;
  assign sclk_rise = sclk_s && !sclk_d_r && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_r && !cs_n_s;
  assign cs_start = !cs_n_s && cs_n_d_r;
  assign cs_end = cs_n_s && !cs_n_d_r;
  assign fs_rise = fs_s && !fs_d_r;
  assign ref_rise = ref_s && !ref_d_r;

  // soft reset from command or long frame for one cycle, or from the reset pin while it is low
  logic cmd_reset_r;
  logic soft_rst;
  assign soft_rst = cmd_reset_r || !pin_rst_n_s;
  assign internal_reset_n = !soft_rst;

  // byte shifter: msb first, last eight edges kept
  logic [7:0] shift_r;
  logic [4:0] edge_cnt_r;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_r <= 8'h00;
      edge_cnt_r <= 5'd0;
    end
    else if (cs_start)
    begin
      edge_cnt_r <= 5'd0;
    end
    else if (sclk_rise)
    begin
      shift_r <= {shift_r[6:0], sdi_s};
      if (edge_cnt_r != RESET_EDGES)
        edge_cnt_r <= edge_cnt_r + 5'd1;
    end
  end

  logic byte_done;
  logic long_frame;
  assign byte_done = cs_end && edge_cnt_r >= BYTE_EDGES && edge_cnt_r < RESET_EDGES;
  assign long_frame = cs_end && edge_cnt_r == RESET_EDGES;

  // command sequencer
  qcmsc_state_t state_r;
  logic [7:0] cmd_r;
  logic [7:0] rdata_r;
  logic [7:0] clk_slot_r;
  logic [7:0] config_r;
  logic [7:0] tx_reg_r [NCH];
  logic [7:0] rx_reg_r [NCH];
  logic any_en;
  assign any_en = |chan_enable;

  // read source: first enabled channel
  logic [7:0] rd_sel;
  always_comb
  begin
    rd_sel = 8'h00;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (chan_enable[i])
        rd_sel = (shift_r == CMD_RD_TX_SLOT) ? tx_reg_r[i] : rx_reg_r[i];
    end
    case (shift_r)
      CMD_RD_CLK_SLOT: rd_sel = clk_slot_r;
      CMD_RD_CONFIG: rd_sel = config_r;
      default: ;
    endcase
  end

  logic is_read;
  logic is_write;
  always_comb
  begin
    is_read = 1'b0;
    is_write = 1'b0;
    case (shift_r)
      CMD_RD_TX_SLOT, CMD_RD_RX_SLOT: is_read = any_en;
      CMD_WR_TX_SLOT, CMD_WR_RX_SLOT: is_write = 1'b1;
      CMD_RD_CLK_SLOT: is_read = any_en;
      CMD_WR_CLK_SLOT: is_write = any_en;
      CMD_RD_CONFIG: is_read = 1'b1;
      CMD_WR_CONFIG: is_write = 1'b1;
      default: ;
    endcase
  end

  logic activate_p;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= QCMSC_IDLE;
      cmd_r <= 8'h00;
      rdata_r <= 8'h00;
      cmd_reset_r <= 1'b0;
      activate_p <= 1'b0;
    end
    else
    begin
      cmd_reset_r <= long_frame;
      activate_p <= 1'b0;
      if (soft_rst)
        state_r <= QCMSC_IDLE;
      else
        case (state_r)
          QCMSC_IDLE:
          begin
            if (byte_done)
            begin
              cmd_r <= shift_r;
              if (shift_r == CMD_HW_RESET)
                cmd_reset_r <= 1'b1;
              else if (shift_r == CMD_ACTIVATE)
                activate_p <= 1'b1;
              else if (is_read)
              begin
                rdata_r <= rd_sel;
                state_r <= QCMSC_RDATA;
              end
              else if (is_write)
                state_r <= QCMSC_WDATA;
              // nop and unknown bytes fall through unchanged
            end
          end
          QCMSC_WDATA:
          begin
            if (byte_done)
              state_r <= QCMSC_IDLE;
          end
          QCMSC_RDATA:
          begin
            if (cs_end)
              state_r <= QCMSC_IDLE;
            else if (sclk_fall)
              rdata_r <= {rdata_r[6:0], 1'b0};
          end
          default: state_r <= QCMSC_IDLE;
        endcase
    end
  end

  // read data: msb shown as soon as chip select falls
  assign serial_port_data_out = rdata_r[7];
  assign serial_port_data_oe_n = !(state_r == QCMSC_RDATA && !cs_n_s);

  logic wr_stb;
  assign wr_stb = state_r == QCMSC_WDATA && byte_done && !soft_rst;

  // per-channel slot registers and activation
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      localparam logic [7:0] SLOT_RST = 8'(g);
      logic [1:0] sync_cnt_r;
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tx_reg_r[g] <= SLOT_RST;
          rx_reg_r[g] <= SLOT_RST;
        end
        else if (soft_rst)
        begin
          tx_reg_r[g] <= SLOT_RST;
          rx_reg_r[g] <= SLOT_RST;
        end
        else if (wr_stb && chan_enable[g])
        begin
          if (cmd_r == CMD_WR_TX_SLOT)
            tx_reg_r[g] <= shift_r;
          if (cmd_r == CMD_WR_RX_SLOT)
            rx_reg_r[g] <= shift_r;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          channel_active_flag[g] <= 1'b0;
          sync_cnt_r <= 2'd0;
        end
        else if (soft_rst)
        begin
          channel_active_flag[g] <= 1'b0;
          sync_cnt_r <= 2'd0;
        end
        else if (activate_p && chan_enable[g])
        begin
          channel_active_flag[g] <= 1'b1;
          sync_cnt_r <= 2'd0;
        end
        else if (channel_active_flag[g] && fs_rise && sync_cnt_r != SYNC_WAIT)
          sync_cnt_r <= sync_cnt_r + 2'd1;
      end
      assign pcm_valid[g] = channel_active_flag[g] && sync_cnt_r == SYNC_WAIT;
      assign tx_slot_number[g*7 +: 7] = tx_reg_r[g][6:0];
      assign rx_slot_number[g*7 +: 7] = rx_reg_r[g][6:0];
      assign tx_highway_sel[g] = tx_reg_r[g][HWY_BIT];
      assign rx_highway_sel[g] = rx_reg_r[g][HWY_BIT];
      assign tx_drive_a[g] = pcm_valid[g]
        && (clk_slot_r[DUAL_TX_BIT] || !tx_highway_sel[g]);
      assign tx_drive_b[g] = pcm_valid[g]
        && (clk_slot_r[DUAL_TX_BIT] || tx_highway_sel[g]);
    end
  endgenerate

  // shared clock slot and configuration bytes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_slot_r <= CLK_SLOT_RST;
      config_r <= CONFIG_RST;
    end
    else if (soft_rst)
    begin
      clk_slot_r <= CLK_SLOT_RST;
      config_r <= CONFIG_RST;
    end
    else if (wr_stb)
    begin
      if (cmd_r == CMD_WR_CLK_SLOT)
        clk_slot_r <= shift_r;
      if (cmd_r == CMD_WR_CONFIG)
        config_r <= shift_r;
    end
  end

  assign tx_edge_select = clk_slot_r[EDGE_BIT];
  assign rx_clock_offset = clk_slot_r[RX_OFS_LSB +: 3];
  assign tx_clock_offset = clk_slot_r[TX_OFS_LSB +: 3];
  assign irq_driver_type = config_r[IRQ_TYPE_BIT];
  assign chopper_divide_sel = config_r[CHOP_BIT];
  assign highway_signaling_en = config_r[SIG_BIT];
  assign master_clock_source = config_r[MCLK_SRC_BIT];
  assign master_freq_select = config_r[FREQ_LSB +: 4];
  assign master_freq_reserved = master_freq_select[3:2] == 2'b11
    || master_freq_select[1:0] == 2'b11;

  // chopper clock: reference divided by 8 or 7
  logic [2:0] chop_cnt_r;
  logic [2:0] chop_last;
  assign chop_last = chopper_divide_sel ? CHOP_DIV7_LAST : CHOP_DIV8_LAST;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chop_cnt_r <= 3'd0;
      chopper_clk <= 1'b0;
    end
    else if (ref_rise)
    begin
      chop_cnt_r <= (chop_cnt_r >= chop_last) ? 3'd0 : chop_cnt_r + 3'd1;
      chopper_clk <= chop_cnt_r < 3'd4;
    end
  end
endmodule : qcmsc_core

// file: verilog/qcmsc_pkg.sv
package qcmsc_pkg;
  // command bytes
  localparam logic [7:0] CMD_HW_RESET = 8'h04;
  localparam logic [7:0] CMD_NOP = 8'h06;
  localparam logic [7:0] CMD_ACTIVATE = 8'h0E;
  localparam logic [7:0] CMD_WR_TX_SLOT = 8'h40;
  localparam logic [7:0] CMD_RD_TX_SLOT = 8'h41;
  localparam logic [7:0] CMD_WR_RX_SLOT = 8'h42;
  localparam logic [7:0] CMD_RD_RX_SLOT = 8'h43;
  localparam logic [7:0] CMD_WR_CLK_SLOT = 8'h44;
  localparam logic [7:0] CMD_RD_CLK_SLOT = 8'h45;
  localparam logic [7:0] CMD_WR_CONFIG = 8'h46;
  localparam logic [7:0] CMD_RD_CONFIG = 8'h47;
  // reset values
  localparam logic [7:0] CLK_SLOT_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h9A;
  localparam logic [3:0] CHAN_EN_RST = 4'hF;
  // field positions
  localparam int HWY_BIT = 7;
  localparam int DUAL_TX_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam int RX_OFS_LSB = 3;
  localparam int TX_OFS_LSB = 0;
  localparam int IRQ_TYPE_BIT = 7;
  localparam int CHOP_BIT = 6;
  localparam int SIG_BIT = 5;
  localparam int MCLK_SRC_BIT = 4;
  localparam int FREQ_LSB = 0;
  // serial framing counts
  localparam logic [4:0] BYTE_EDGES = 5'd8;
  localparam logic [4:0] RESET_EDGES = 5'd16;
  // frame syncs after activation before valid pcm
  localparam logic [1:0] SYNC_WAIT = 2'd2;
  // chopper divisors
  localparam logic [2:0] CHOP_DIV8_LAST = 3'd7;
  localparam logic [2:0] CHOP_DIV7_LAST = 3'd6;

  typedef enum logic [1:0]
  {
    QCMSC_IDLE = 2'b00,
    QCMSC_WDATA = 2'b01,
    QCMSC_RDATA = 2'b10
  } qcmsc_state_t;
endpackage : qcmsc_pkg
